// ==== adc_link_regs.svh ====
// constants for the converter command link: field positions, reset values, frame counts
`ifndef ADC_LINK_REGS_SVH
`define ADC_LINK_REGS_SVH

// -----------------------------------------------------------------------------
// command word fields
// -----------------------------------------------------------------------------
`define CMD_CHAN_MSB 7
`define CMD_CHAN_LSB 5
`define CMD_SCAN_MSB 4
`define CMD_SCAN_LSB 3
`define CMD_REF_MSB 2
`define CMD_REF_LSB 1
`define CMD_CLK_BIT 0
`define CMD_RESET_VAL 8'h06

// -----------------------------------------------------------------------------
// frame edge counts (serial clock cycles)
// -----------------------------------------------------------------------------
`define EDGE_CHAN_SEL 6'h03
`define EDGE_CMD_DONE 6'h08
`define EDGE_SAMPLE_8 6'h06
`define EDGE_SAMPLE_16 6'h0e
`define EDGE_DATA_8 6'h08
`define EDGE_DATA_16 6'h10
`define RESULT_BITS 16
`define FRAME_LEN_8 6'h18
`define FRAME_LEN_16 6'h20

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define CLK_SYS_NS 40
`define REF_WAKE_MS 5
`define REF_WAKE_CYC ((`REF_WAKE_MS * 1000000) / `CLK_SYS_NS)
`define SCLK_HALF_CYC 4

`endif

// ==== adc_link_pkg.sv ====
// types shared by both ends of the converter command link
package adc_link_pkg;

  // reference power field codes
  typedef enum logic [1:0] {
    REF_ALWAYS_ON = 2'b00,
    REF_BOTH_OFF = 2'b01,
    REF_BUF_OFF = 2'b10,
    REF_EXTERNAL = 2'b11
  } ref_power_e;

  // scan field codes
  typedef enum logic [1:0] {
    SCAN_SINGLE = 2'b00,
    SCAN_FROM_ZERO = 2'b01,
    SCAN_FROM_MID = 2'b10,
    SCAN_REPEAT = 2'b11
  } scan_mode_e;

  // device frame phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CMD = 2'b01,
    PH_CONV = 2'b10,
    PH_DONE = 2'b11
  } frame_phase_e;

  // host sequencer states
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LOW = 2'b01,
    HS_HIGH = 2'b10,
    HS_GAP = 2'b11
  } host_state_e;

endpackage

// ==== adc_link_if.sv ====
// serial link between host and converter control
`timescale 1ns/1ps
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic frame_sync_in;
  logic width_select;
  logic dout_o;
  logic dout_oe;
  logic dout;

  // dout is released (high) whenever the device does not drive it
  assign dout = dout_oe ? dout_o : 1'b1;

  modport device (
    input cs_n,
    input sclk,
    input din,
    input frame_sync_in,
    input width_select,
    output dout_o,
    output dout_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output din,
    output frame_sync_in,
    output width_select,
    input dout
  );
endinterface

// ==== sync_2ff.sv ====
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module sync_2ff #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      meta_q <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ==== adc_device_end.sv ====
// converter-side command decode and external-clock frame sequencer
// Contract
// - bits 7:5 pick analog input 0..7
// - eight-input scan field meanings decoded
// - four-input scan field meanings decoded
// - scans only act in internal-clock mode
// - bits 2:1 select reference power state
// - power state applied on chip select rise
// - wake reference on cs or sync fall
// - host waits 5 ms after full shutdown
// - bit 0 selects conversion clock source
// - host holds sync high, width selects framing
// - dout released while idle, low until data
// - din latched on rising serial clock
// - 8-bit: channel edge 3, sample fall 6; chan_sel_o only changes with the command at rising edge 8
// - command complete at rising edge 8
// - 8-bit: result from fall 8, 24 cycles
// - zeros shifted after result is out
// - 16-bit: acquire edge 3, sample fall 14
// - 16-bit: result from fall 16, 32 cycles
// - cs rise mid-conversion aborts to shutdown; code aborts and sets power from bits 2:1 as at any cs rise
// - host raises cs after reading result
// - command layout and power-up value 06
// - command kept over chip select activity
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "adc_link_regs.svh"
module adc_device_end #(
  parameter int NUM_INPUTS = 8
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  adc_link_if.device link,
  input wire logic [13:0] sample_data_i,
  output logic [2:0] chan_sel_o,
  output logic [2:0] scan_first_o,
  output logic [2:0] scan_count_o,
  output logic acquire_o,
  output logic sample_o,
  output logic convert_o,
  output logic ref_on_o,
  output logic buf_on_o,
  output logic int_clock_o,
  output logic frame_sync_mode_o,
  output logic [7:0] command_o
);

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic cs_n_s, sclk_s, din_s, fsync_s, width_s;

  sync_2ff #(.RESET_VAL(1'b1)) u_cs (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .d_i(link.cs_n), .q_o(cs_n_s));
  sync_2ff #(.RESET_VAL(1'b0)) u_sclk (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .d_i(link.sclk), .q_o(sclk_s));
  sync_2ff #(.RESET_VAL(1'b0)) u_din (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .d_i(link.din), .q_o(din_s));
  sync_2ff #(.RESET_VAL(1'b1)) u_fs (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .d_i(link.frame_sync_in), .q_o(fsync_s));
  sync_2ff #(.RESET_VAL(1'b0)) u_ws (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .d_i(link.width_select), .q_o(width_s));

  // ---------------------------------------------------------------------------
  // edge detection on synchronised levels
  // ---------------------------------------------------------------------------
  logic cs_n_q, sclk_q, fsync_q;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      fsync_q <= 1'b1;
    end else begin
      cs_n_q <= cs_n_s;
      sclk_q <= sclk_s;
      fsync_q <= fsync_s;
    end
  end

  wire cs_fall = cs_n_q & ~cs_n_s;
  wire cs_rise = ~cs_n_q & cs_n_s;
  wire sclk_rise = ~sclk_q & sclk_s & ~cs_n_s;
  wire sclk_fall = sclk_q & ~sclk_s & ~cs_n_s;
  wire fsync_fall = fsync_q & ~fsync_s;

  // ---------------------------------------------------------------------------
  // frame counters and command shifter
  // ---------------------------------------------------------------------------
  // edge counters saturate so a long frame never wraps back into command phase
  logic [5:0] rise_cnt_q, fall_cnt_q;
  logic [7:0] shift_q, command_q;
  logic wide_q;
  adc_link_pkg::frame_phase_e phase_q, phase_d;

  wire [5:0] rise_next = rise_cnt_q + 6'h01;
  wire [5:0] fall_next = fall_cnt_q + 6'h01;
  wire rise_sat = &rise_cnt_q;
  wire fall_sat = &fall_cnt_q;
  wire cmd_bit_edge = sclk_rise & (rise_cnt_q < `EDGE_CMD_DONE);
  wire cmd_done = sclk_rise & (rise_next == `EDGE_CMD_DONE);
  wire [7:0] shift_next = {shift_q[6:0], din_s};

  // width is sampled at cs fall and kept for the frame
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rise_cnt_q <= 6'h00;
      fall_cnt_q <= 6'h00;
      shift_q <= 8'h00;
      wide_q <= 1'b0;
    end else if (cs_fall) begin
      rise_cnt_q <= 6'h00;
      fall_cnt_q <= 6'h00;
      wide_q <= width_s;
    end else begin
      if (sclk_rise && !rise_sat) rise_cnt_q <= rise_next;
      if (sclk_fall && !fall_sat) fall_cnt_q <= fall_next;
      if (cmd_bit_edge) shift_q <= shift_next;
    end
  end

  // command survives chip select; only the system reset restores it
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      command_q <= `CMD_RESET_VAL;
    end else if (cmd_done) begin
      command_q <= shift_next;
    end
  end

  // ---------------------------------------------------------------------------
  // decode of the command word
  // ---------------------------------------------------------------------------
  wire [2:0] chan_field = command_q[`CMD_CHAN_MSB:`CMD_CHAN_LSB];
  wire [1:0] scan_field = command_q[`CMD_SCAN_MSB:`CMD_SCAN_LSB];
  wire [1:0] ref_field = command_q[`CMD_REF_MSB:`CMD_REF_LSB];
  wire int_clk = command_q[`CMD_CLK_BIT];
  wire eight_in = (NUM_INPUTS == 8);
  wire [2:0] chan_max = eight_in ? 3'h7 : 3'h3;
  wire [2:0] chan_lim = (chan_field > chan_max) ? chan_max : chan_field;
  wire [2:0] mid_chan = eight_in ? 3'h4 : 3'h2;
  wire [2:0] repeat_n = eight_in ? 3'h7 : 3'h3;
  wire scan_ok = int_clk & fsync_s;
  logic [2:0] scan_first, scan_count;

  // scan plan: first channel and number of conversions minus one
  always_comb begin
    scan_first = chan_lim;
    scan_count = 3'h0;
    if (scan_ok) begin
      case (adc_link_pkg::scan_mode_e'(scan_field))
        adc_link_pkg::SCAN_SINGLE: scan_count = 3'h0;
        adc_link_pkg::SCAN_FROM_ZERO: begin
          scan_first = 3'h0;
          scan_count = chan_lim;
        end
        adc_link_pkg::SCAN_FROM_MID: begin
          scan_first = mid_chan;
          scan_count = (chan_lim > mid_chan) ? 3'(chan_lim - mid_chan) : 3'h0;
        end
        adc_link_pkg::SCAN_REPEAT: scan_count = repeat_n;
        default: scan_count = 3'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // frame sequencing
  // ---------------------------------------------------------------------------
  wire [5:0] sample_edge = wide_q ? `EDGE_SAMPLE_16 : `EDGE_SAMPLE_8;
  wire [5:0] data_edge = wide_q ? `EDGE_DATA_16 : `EDGE_DATA_8;
  wire acq_start = sclk_rise & (rise_next == `EDGE_CHAN_SEL);
  wire sample_now = sclk_fall & (fall_next == sample_edge);
  wire data_now = sclk_fall & (fall_next == data_edge);
  logic acq_q, conv_q, sample_q;
  logic [`RESULT_BITS-1:0] out_sr_q;

  // phase advances on the counted edges; cs rise wins over everything
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      adc_link_pkg::PH_IDLE: if (cs_fall) phase_d = adc_link_pkg::PH_CMD;
      adc_link_pkg::PH_CMD: if (sample_now) phase_d = adc_link_pkg::PH_CONV;
      adc_link_pkg::PH_CONV: if (data_now) phase_d = adc_link_pkg::PH_DONE;
      adc_link_pkg::PH_DONE: phase_d = adc_link_pkg::PH_DONE;
      default: phase_d = adc_link_pkg::PH_IDLE;
    endcase
    if (cs_rise) phase_d = adc_link_pkg::PH_IDLE;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      phase_q <= adc_link_pkg::PH_IDLE;
      acq_q <= 1'b0;
      conv_q <= 1'b0;
      sample_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      sample_q <= sample_now & ~cs_rise;
      if (cs_rise || sample_now) acq_q <= 1'b0;
      else if (acq_start) acq_q <= 1'b1;
      if (cs_rise || data_now) conv_q <= 1'b0;
      else if (sample_now) conv_q <= 1'b1;
    end
  end

  // result loads at the data edge, then zeros follow it out
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      out_sr_q <= '0;
    end else if (cs_fall) begin
      out_sr_q <= '0;
    end else if (data_now) begin
      out_sr_q <= {sample_data_i, 2'b00};
    end else if (sclk_fall && phase_q == adc_link_pkg::PH_DONE) begin
      out_sr_q <= {out_sr_q[`RESULT_BITS-2:0], 1'b0};
    end
  end

  // ---------------------------------------------------------------------------
  // reference power control
  // ---------------------------------------------------------------------------
  // power state only follows the command at cs rise; wake on the framing fall
  logic ref_on_q, buf_on_q;
  wire fs_mode = ~fsync_s;
  wire wake = fs_mode ? fsync_fall : cs_fall;
  wire ext_ref = (ref_field == adc_link_pkg::REF_EXTERNAL);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ref_on_q <= 1'b0;
      buf_on_q <= 1'b0;
    end else if (cs_rise) begin
      ref_on_q <= (ref_field == adc_link_pkg::REF_ALWAYS_ON) ||
                  (ref_field == adc_link_pkg::REF_BUF_OFF);
      buf_on_q <= (ref_field == adc_link_pkg::REF_ALWAYS_ON);
    end else if (wake && !ext_ref) begin
      ref_on_q <= 1'b1;
      buf_on_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign link.dout_oe = ~cs_n_s;
  assign link.dout_o = out_sr_q[`RESULT_BITS-1];
  assign chan_sel_o = chan_lim;
  assign scan_first_o = scan_first;
  assign scan_count_o = scan_count;
  assign acquire_o = acq_q;
  assign sample_o = sample_q;
  assign convert_o = conv_q;
  assign ref_on_o = ref_on_q;
  assign buf_on_o = buf_on_q;
  assign int_clock_o = int_clk;
  assign frame_sync_mode_o = fs_mode;
  assign command_o = command_q;
endmodule

// ==== adc_host_end.sv ====
// host-side serial master: sends a command and collects one result per frame
`timescale 1ns/1ps
`include "adc_link_regs.svh"
module adc_host_end #(
  parameter int WAKE_CYC = `REF_WAKE_CYC,
  parameter int HALF_CYC = `SCLK_HALF_CYC
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  adc_link_if.host link,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o
);
  // register map: 0 command+go, 1 control, 2 result, 3 status
  localparam logic [3:0] A_CMD = 4'h0;
  localparam logic [3:0] A_CTRL = 4'h1;
  localparam logic [3:0] A_RES = 4'h2;
  localparam logic [3:0] A_STAT = 4'h3;

  logic dout_s;
  sync_2ff #(.RESET_VAL(1'b1)) u_dout (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .d_i(link.dout), .q_o(dout_s));

  adc_link_pkg::host_state_e st_q;
  logic [7:0] cmd_q;
  logic wide_q, wait_q, done_q, start_q, sclk_q;
  logic [15:0] res_q, rx_q;
  logic [5:0] bit_q;
  logic [31:0] tmr_q;
  logic [15:0] rdata_q;

  wire wr_cmd = wr_i & (addr_i == A_CMD);
  wire wr_ctrl = wr_i & (addr_i == A_CTRL);
  wire [5:0] frame_len = wide_q ? `FRAME_LEN_16 : `FRAME_LEN_8;
  wire tmr_zero = (tmr_q == 32'h0);
  wire busy = (st_q != adc_link_pkg::HS_IDLE);
  // wait after full internal shutdown, none for an external reference
  wire need_wait = wait_q &
                   (cmd_q[`CMD_REF_MSB:`CMD_REF_LSB] != adc_link_pkg::REF_EXTERNAL);

  // read mux: data the cycle after the strobe
  wire [15:0] rd_mux = (addr_i == A_CMD) ? {8'h00, cmd_q} :
                       (addr_i == A_CTRL) ? {14'h0, wait_q, wide_q} :
                       (addr_i == A_RES) ? res_q :
                       (addr_i == A_STAT) ? {14'h0, done_q, busy} : 16'h0000;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_q <= 16'h0000;
      cmd_q <= `CMD_RESET_VAL;
      wide_q <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      rdata_q <= rd_i ? rd_mux : 16'h0000;
      if (wr_cmd && !busy) cmd_q <= wdata_i[7:0];
      if (wr_ctrl && !busy) wide_q <= wdata_i[0];
      if (wr_ctrl && !busy) wait_q <= wdata_i[1];
    end
  end

  // frame sequencer: cs low, optional wake wait, then full-period sclk stream
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_q <= adc_link_pkg::HS_IDLE;
      start_q <= 1'b0;
      sclk_q <= 1'b0;
      bit_q <= 6'h00;
      tmr_q <= 32'h0;
      rx_q <= 16'h0000;
      res_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      start_q <= wr_cmd & ~busy;
      if (rd_i && addr_i == A_RES) done_q <= 1'b0;
      case (st_q)
        adc_link_pkg::HS_IDLE: if (start_q) begin
          st_q <= adc_link_pkg::HS_LOW;
          bit_q <= 6'h00;
          tmr_q <= need_wait ? 32'(WAKE_CYC) : 32'(HALF_CYC);
        end
        adc_link_pkg::HS_LOW: if (tmr_zero) begin
          sclk_q <= 1'b1;
          st_q <= adc_link_pkg::HS_HIGH;
          tmr_q <= 32'(HALF_CYC);
        end else tmr_q <= tmr_q - 32'h1;
        // dout is taken at the end of the high half: the loop through both synchronisers
        // and the device shifter takes five cycles, one too many for the rising edge
        adc_link_pkg::HS_HIGH: if (tmr_zero) begin
          sclk_q <= 1'b0;
          if (bit_q >= frame_len - 6'h10) rx_q <= {rx_q[14:0], dout_s};
          tmr_q <= 32'(HALF_CYC);
          bit_q <= bit_q + 6'h01;
          st_q <= (bit_q + 6'h01 == frame_len) ? adc_link_pkg::HS_GAP : adc_link_pkg::HS_LOW;
        end else tmr_q <= tmr_q - 32'h1;
        adc_link_pkg::HS_GAP: if (tmr_zero) begin
          st_q <= adc_link_pkg::HS_IDLE;
          res_q <= rx_q;
          done_q <= 1'b1;
        end else tmr_q <= tmr_q - 32'h1;
        default: st_q <= adc_link_pkg::HS_IDLE;
      endcase
    end
  end

  wire [7:0] tx_byte = cmd_q << bit_q[2:0];
  assign link.cs_n = (st_q == adc_link_pkg::HS_IDLE) | (st_q == adc_link_pkg::HS_GAP);
  assign link.sclk = sclk_q;
  assign link.din = (bit_q < 6'h08) ? tx_byte[7] : 1'b0;
  assign link.frame_sync_in = 1'b1;
  assign link.width_select = wide_q;
  assign rdata_o = rdata_q;
endmodule

// ==== adc_link_checker.sv ====
// concurrent checks on the serial link joining host and converter ends
`timescale 1ns/1ps
`include "adc_link_regs.svh"
module adc_link_checker (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic frame_sync_in,
  input wire logic width_select,
  input wire logic dout_o,
  input wire logic dout_oe
);
  // ----------
  // edge counts within a frame
  // ----------
  logic sclk_q;
  logic [5:0] rise_q;
  logic [5:0] fall_q;
  logic [5:0] data_edge;
  // counts restart while deselected so an aborted frame cannot leak into the next
  always_ff @(posedge clk_sys_i) begin
    sclk_q <= sclk;
    if (srst_i || cs_n) begin
      rise_q <= 6'h00;
      fall_q <= 6'h00;
    end else begin
      rise_q <= rise_q + 6'(sclk && !sclk_q);
      fall_q <= fall_q + 6'(!sclk && sclk_q);
    end
  end
  assign data_edge = width_select ? `EDGE_DATA_16 : `EDGE_DATA_8;

  // ----------
  // assertions
  // ----------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // five cycles leave room for the chip select synchroniser
  AST_DOUT_OFF: assert property (cs_n [*5] |-> !dout_oe)
    else $error("dout driven while deselected");
  AST_DOUT_ON: assert property (!cs_n [*5] |-> dout_oe)
    else $error("dout released inside a frame");
  AST_DOUT_LOW: assert property (!cs_n && dout_oe && fall_q < data_edge |-> !dout_o)
    else $error("dout not low before result");
  AST_ZERO_TAIL: assert property (!cs_n && dout_oe && fall_q > data_edge + 6'd14 |-> !dout_o)
    else $error("dout not zero after result");
  AST_FRAME_LEN: assert property ($rose(cs_n) |->
      rise_q == (width_select ? `FRAME_LEN_16 : `FRAME_LEN_8))
    else $error("wrong clock count in frame");
  AST_SYNC_HIGH: assert property (frame_sync_in)
    else $error("frame sync input not held high");
  AST_WIDTH_HELD: assert property (!cs_n [*2] |-> $stable(width_select))
    else $error("width select moved inside a frame");
  AST_DIN_HELD: assert property (!cs_n && $rose(sclk) |-> $stable(din))
    else $error("din changed at a rising serial clock");
  // main scenarios
  cover property ($rose(cs_n) && !width_select);
  cover property ($rose(cs_n) && width_select);
  cover property (!cs_n && fall_q > data_edge + 6'd14);
endmodule

// ==== tb.sv ====
// self-checking bench: host end and converter end joined over the link
`timescale 1ns/1ps
`include "adc_link_regs.svh"
module tb;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [13:0] sample_data = 14'h0000;
  logic [15:0] rdata;
  logic [7:0] command;
  logic [2:0] chan_sel, scan_first, scan_count;
  logic acq, smp, conv, ref_on, buf_on, int_clk, fs_mode;
  logic sclk_q, acq_q;
  logic [5:0] nr, nf;
  logic cur_wide = 1'b0;
  logic [1:0] prev_ref = 2'b11;
  int fail_count = 0;
  int samples_checked = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  adc_link_if link ();
  adc_host_end #(.WAKE_CYC(10), .HALF_CYC(`SCLK_HALF_CYC)) i_adc_host_end (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .link(link), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata));
  adc_device_end #(.NUM_INPUTS(8)) i_adc_device_end (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .link(link), .sample_data_i(sample_data),
    .chan_sel_o(chan_sel), .scan_first_o(scan_first), .scan_count_o(scan_count),
    .acquire_o(acq), .sample_o(smp), .convert_o(conv), .ref_on_o(ref_on), .buf_on_o(buf_on),
    .int_clock_o(int_clk), .frame_sync_mode_o(fs_mode), .command_o(command));
  adc_link_checker i_adc_link_checker (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .cs_n(link.cs_n), .sclk(link.sclk),
    .din(link.din), .frame_sync_in(link.frame_sync_in), .width_select(link.width_select),
    .dout_o(link.dout_o), .dout_oe(link.dout_oe));

  // ----------
  // compare, bus and model helpers
  // ----------
  task chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task chk_evt(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t event at edge %0d expected %0d", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys_i);
    wr_s <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_i);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  // expected scan plan; scans never act on an external-clock command
  function automatic logic [2:0] exp_count(input logic [7:0] c);
    if (!c[0]) return 3'h0;
    case (c[4:3])
      2'b00: return 3'h0;
      2'b01: return c[7:5];
      2'b10: return c[7:5] - 3'h4;
      default: return 3'h7;
    endcase
  endfunction
  function automatic logic [2:0] exp_first(input logic [7:0] c);
    if (!c[0]) return c[7:5];
    case (c[4:3])
      2'b01: return 3'h0;
      2'b10: return 3'h4;
      default: return c[7:5];
    endcase
  endfunction

  // one whole frame; a second command sent while busy must be ignored
  task frame(input logic [7:0] c, input logic wide, input logic wake);
    logic [15:0] v;
    int n;
    cur_wide = wide;
    @(posedge clk_sys_i);
    sample_data <= 14'($urandom);
    wr(4'h1, {14'h0000, wake, wide});
    wr(4'h0, {8'h00, c});
    wr(4'h0, {8'h00, ~c});
    repeat (20) @(posedge clk_sys_i);
    n = 0;
    v = 16'h0001;
    while (v[0] === 1'b1 && n < 3000) begin
      rd(4'h3, v);
      n++;
    end
    chk_val(v[1:0], 2'b10);
    rd(4'h2, v);
    if (!c[0]) chk_val(v, {sample_data, 2'b00});
    rd(4'h3, v);
    chk_val(v[1], 1'b0);
    chk_val(conv, 1'b0);
    chk_val(command, c);
    chk_val(chan_sel, c[7:5]);
    chk_val(int_clk, c[0]);
    chk_val(scan_count, exp_count(c));
    chk_val(scan_first, exp_first(c));
    chk_val({ref_on, buf_on}, {~c[1], c[2:1] == 2'b00});
    chk_val(fs_mode, 1'b0);
    prev_ref = c[2:1];
  endtask

  // ----------
  // frame monitor: sequencing events against serial clock edges
  // ----------
  always @(posedge clk_sys_i) begin
    sclk_q <= link.sclk;
    acq_q <= acq;
    if (link.cs_n) begin
      nr <= 6'h00;
      nf <= 6'h00;
    end else begin
      nr <= nr + 6'(link.sclk && !sclk_q);
      nf <= nf + 6'(!link.sclk && sclk_q);
    end
    if (acq && !acq_q) begin
      chk_evt(nr, `EDGE_CHAN_SEL);
      chk_val({ref_on, buf_on}, {2{prev_ref != 2'b11}});
    end
    // conversion starts together with the sample pulse
    if (smp) begin
      chk_evt(nf, cur_wide ? `EDGE_SAMPLE_16 : `EDGE_SAMPLE_8);
      chk_val(conv, 1'b1);
    end
  end

  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------
  // main sequence
  // ----------
  initial begin
    logic [7:0] c;
    void'($urandom(26973));
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1;
    chk_val(command, `CMD_RESET_VAL);
    chk_val({ref_on, buf_on, link.dout_oe}, 3'b000);
    wr(4'h9, 16'h00ff);
    repeat (4) @(posedge clk_sys_i);
    chk_val(command, `CMD_RESET_VAL);
    // every channel, every reference code, both widths, external clock
    for (int i = 0; i < 16; i++) begin
      c = 8'($urandom);
      c[7:5] = 3'(i);
      c[2:1] = 2'(i >> 2);
      c[0] = 1'b0;
      frame(c, i[0], i[1]);
    end
    // every scan code with the internal clock bit set
    for (int i = 0; i < 4; i++) begin
      c = {3'h4 | 3'($urandom), 2'(i), 2'($urandom), 1'b1};
      frame(c, i[0], 1'b0);
    end
    stop_test;
  end

  // twenty frames need under 10k cycles; 100k cycles means a hang
  initial begin
    #4000000;
    fail_count++;
    stop_test;
  end
endmodule
